//--- logic/otp_page2_pkg.sv
// Constants for the customer page two status block: register map,
// field positions, reset values, interrupt layout and tracker states.
// Assumes one core clock domain shared by every user of the package.
package otp_page2_pkg;

   // Register port geometry
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;

   // Register offsets on the plain register port
   localparam logic [15:0] CUST_PAGE2_STATUS_ADDR = 16'h051b;
   localparam logic [15:0] IRQ_STATUS_ADDR        = 16'h0520;
   localparam logic [15:0] IRQ_MASK_ADDR          = 16'h0521;

   // Reset values
   localparam logic [7:0] CUST_PAGE2_STATUS_RST = 8'h00;
   localparam logic [3:0] IRQ_STATUS_RST        = 4'h0;
   localparam logic [3:0] IRQ_MASK_RST          = 4'h0;

   // Field positions inside customer_page2_status
   localparam int unsigned LOADED_BIT       = 7;
   localparam int unsigned LOAD_WARN_BIT    = 6;
   localparam int unsigned LOAD_ERR_BIT     = 5;
   localparam int unsigned FMT_ERR_BIT      = 4;
   localparam int unsigned PAGE_VALID_BIT   = 3;
   localparam int unsigned NOT_LOW_BIT      = 2;
   localparam int unsigned NOT_HIGH_BIT     = 1;
   localparam int unsigned FIRST_ATTEMPT_BIT = 0;

   // Interrupt status and mask layout
   localparam int unsigned IRQ_W            = 4;
   localparam int unsigned IRQ_LOAD_DONE    = 0;
   localparam int unsigned IRQ_LOAD_FAULT   = 1;
   localparam int unsigned IRQ_PROG_DONE    = 2;
   localparam int unsigned IRQ_SUPPLY_FAULT = 3;

   // Positions in the restore word taken from the nonvolatile record
   localparam int unsigned RS_W        = 4;
   localparam int unsigned RS_VALID    = 3;
   localparam int unsigned RS_NOT_LOW  = 2;
   localparam int unsigned RS_NOT_HIGH = 1;
   localparam int unsigned RS_TRY      = 0;

   // Programming attempt tracker states, one-hot
   typedef enum logic [1:0] {
      PS_IDLE = 2'b01,
      PS_BURN = 2'b10
   } prog_state_t;

endpackage : otp_page2_pkg

//--- logic/otp_page2_status.sv
// Customer page two status register with its interrupt logic.
// Assumes the load engine and programming engine give one-cycle
// pulses synchronous to i_sys_clk, and a plain register port master.
// Nothing here blocks a programming start while the format error reads
// one; keeping away from that is left to host software.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module otp_page2_status
   import otp_page2_pkg::*;
(
   // Clock, reset and enable
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_clk_en,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // Load engine
   input  wire logic              i_load_done,
   input  wire logic              i_load_page2_sel,
   input  wire logic              i_load_sec_warn,
   input  wire logic              i_load_ded_err,
   // Programming engine
   input  wire logic              i_prog_start,
   input  wire logic              i_prog_stop,
   input  wire logic              i_prog_uv,
   input  wire logic              i_prog_ov,
   input  wire logic              i_prog_verify_ok,
   // Record restore at start-up
   input  wire logic              i_restore,
   input  wire logic [RS_W-1:0]   i_restore_flags,
   // Interrupt
   output logic                   o_irq
);

   // Full address compare, shared by the read and write decode,
   // so that an alias one bit away never hits
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] target);
      addr_hit = (a == target);
   endfunction : addr_hit

   // All state of the block outside the tracker
   typedef struct packed {
      logic              loaded;      // Page two chosen and loaded
      logic              warn;        // Corrected errors during load
      logic              err;         // Uncorrectable error during load
      logic [IRQ_W-1:0]  irq_status;  // Sticky events
      logic [IRQ_W-1:0]  irq_mask;    // Event enables
      logic [DATA_W-1:0] rdata;       // Read data, valid one cycle
   } stat_state_t;

   stat_state_t      s;            // Registered state
   stat_state_t      next_s;       // Next state
   logic [7:0]       status_byte;  // Assembled status view
   logic             fmt_err;      // Derived format error
   logic [IRQ_W-1:0] irq_event;    // Events this cycle
   logic [IRQ_W-1:0] irq_clear;    // Write-one-to-clear bits
   logic             wr_irq_stat;  // Write decodes
   logic             wr_irq_mask;
   logic             load_fault;   // Page two load met any error

   prog_track_if pt ();            // Link to the attempt tracker

   // Programming attempt tracker; it owns the four programming flags,
   // while the three load flags and the interrupt live here
   otp_prog_tracker u_tracker (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_clk_en  (i_clk_en),
      .trk       (pt.trk)
   );

   // Drive the tracker from the programming engine pins. The engine
   // is trusted to keep the host rule on format errors; nothing here
   // blocks a start, since the hardware only reports the state.
   assign pt.start         = i_prog_start;
   assign pt.stop          = i_prog_stop;
   assign pt.uv            = i_prog_uv;
   assign pt.ov            = i_prog_ov;
   assign pt.verify_ok     = i_prog_verify_ok;
   assign pt.restore       = i_restore;
   assign pt.restore_flags = i_restore_flags;

   // Supply flags without an attempt mean a corrupt record
   // Kept combinational so a restore shows the record exactly as stored
   assign fmt_err = (pt.not_low | pt.not_high) & ~pt.attempted;

   // Assemble the status byte from flags at their positions
   // Starting from the reset word keeps every bit driven on every path
   always_comb begin
      status_byte                    = CUST_PAGE2_STATUS_RST;
      status_byte[LOADED_BIT]        = s.loaded;
      status_byte[LOAD_WARN_BIT]     = s.warn;
      status_byte[LOAD_ERR_BIT]      = s.err;
      status_byte[FMT_ERR_BIT]       = fmt_err;
      status_byte[PAGE_VALID_BIT]    = pt.page_valid;
      status_byte[NOT_LOW_BIT]       = pt.not_low;
      status_byte[NOT_HIGH_BIT]      = pt.not_high;
      status_byte[FIRST_ATTEMPT_BIT] = pt.attempted;
   end

   // Write decode; the status register itself has no write path
   assign wr_irq_stat = i_wr & addr_hit(i_addr, IRQ_STATUS_ADDR);
   assign wr_irq_mask = i_wr & addr_hit(i_addr, IRQ_MASK_ADDR);

   // Event collection for the interrupt status
   // Supply events count whether or not an attempt runs
   assign load_fault = i_load_page2_sel & (i_load_sec_warn | i_load_ded_err);
   always_comb begin
      irq_event                   = '0;
      irq_event[IRQ_LOAD_DONE]    = i_load_done;
      irq_event[IRQ_LOAD_FAULT]   = i_load_done & load_fault;
      irq_event[IRQ_PROG_DONE]    = i_prog_stop;
      irq_event[IRQ_SUPPLY_FAULT] = i_prog_uv | i_prog_ov;
   end
   // Ones written to the interrupt status address clear those bits
   assign irq_clear = wr_irq_stat ? i_wdata[IRQ_W-1:0] : '0;

   // Next state
   always_comb begin
      // Start from the held state so every field is assigned on every path
      next_s = s;
      // Read data stand for one cycle only
      next_s.rdata = '0;

      // Load result: a load of another page clears all three flags
      // Warning and error only mean anything for a page two load
      if (i_load_done) begin
         next_s.loaded = i_load_page2_sel;
         next_s.warn   = i_load_page2_sel & i_load_sec_warn;
         next_s.err    = i_load_page2_sel & i_load_ded_err;
      end

      // Set wins over a clear in the same cycle
      next_s.irq_status = (s.irq_status & ~irq_clear) | irq_event;

      // Mask takes its new value at the write edge
      if (wr_irq_mask) begin
         next_s.irq_mask = i_wdata[IRQ_W-1:0];
      end

      // Read mux; unmapped addresses read zero
      // The status byte is taken as it stands at the strobe edge
      if (i_rd) begin
         if (addr_hit(i_addr, CUST_PAGE2_STATUS_ADDR)) begin
            next_s.rdata = status_byte;
         end else if (addr_hit(i_addr, IRQ_STATUS_ADDR)) begin
            next_s.rdata = {{(DATA_W-IRQ_W){1'b0}}, s.irq_status};
         end else if (addr_hit(i_addr, IRQ_MASK_ADDR)) begin
            next_s.rdata = {{(DATA_W-IRQ_W){1'b0}}, s.irq_mask};
         end else begin
            next_s.rdata = '0;
         end
      end
   end

   // State register; all flags clear at reset and freeze when disabled
   // Only constants in the reset branch: it must not sample live inputs
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s.loaded     <= CUST_PAGE2_STATUS_RST[LOADED_BIT];
         s.warn       <= CUST_PAGE2_STATUS_RST[LOAD_WARN_BIT];
         s.err        <= CUST_PAGE2_STATUS_RST[LOAD_ERR_BIT];
         s.irq_status <= IRQ_STATUS_RST;
         s.irq_mask   <= IRQ_MASK_RST;
         s.rdata      <= '0;
      end else if (i_clk_en) begin
         s <= next_s;
      end
   end

   // Outputs
   // The interrupt is a level: it stays high until software clears or
   // masks every pending bit
   assign o_rdata = s.rdata;
   assign o_irq   = |(s.irq_status & s.irq_mask);

   // Checks on this block; all live in the core clock domain and sleep
   // through reset, so no check sees the flags while they are cleared
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   // A load that picked page two, taken while enabled
   sequence s_load_sel;
      i_clk_en && i_load_done && i_load_page2_sel;
   endsequence
   // An enabled read of the status register
   sequence s_rd_stat;
      i_clk_en && i_rd && i_addr == CUST_PAGE2_STATUS_ADDR;
   endsequence
   // An enabled write with no read beside it
   sequence s_wr_only;
      i_clk_en && i_wr && !i_rd;
   endsequence

   // Selecting page two raises the loaded flag at the load edge
   property p_loaded_set;
      s_load_sel |=> s.loaded;
   endproperty
   a_loaded_set: assert property (p_loaded_set) else $error("loaded flag not set");

   // A load of any other page clears all three load flags
   property p_other_page;
      i_clk_en && i_load_done && !i_load_page2_sel |=> !s.loaded && !s.warn && !s.err;
   endproperty
   a_other_page: assert property (p_other_page) else $error("flags left after other page");

   // A warning shows at the load edge and still stands one cycle later unless a load result came
   property p_warn_set;
      s_load_sel ##0 i_load_sec_warn |=> s.warn ##1 s.warn || $past(i_load_done);
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("load warning lost");

   // An uncorrectable error shows at the load edge
   property p_err_set;
      s_load_sel ##0 i_load_ded_err |=> s.err;
   endproperty
   a_err_set: assert property (p_err_set) else $error("load error not set");

   // The error flag only moves on a load result
   property p_err_kept;
      !(i_clk_en && i_load_done) |=> $stable(s.err);
   endproperty
   a_err_kept: assert property (p_err_kept) else $error("load error moved");

   // Warning and error only ever describe a page two load
   property p_warn_ld;
      s.warn |-> s.loaded;
   endproperty
   a_warn_ld: assert property (p_warn_ld) else $error("warning without load");
   property p_err_ld;
      s.err |-> s.loaded;
   endproperty
   a_err_ld: assert property (p_err_ld) else $error("error without load");

   // Format error read back from the flags of the cycle of the strobe
   property p_fmt_read;
      s_rd_stat |=> o_rdata[FMT_ERR_BIT] ==
         (($past(pt.not_low) || $past(pt.not_high)) && !$past(pt.attempted));
   endproperty
   a_fmt_read: assert property (p_fmt_read) else $error("format error read wrong");

   // Loaded and the four tracker flags read back as they stood at the read strobe; the tracker
   // flags are checked here since only this block serves the read
   property p_loaded_read;
      s_rd_stat |=> o_rdata[LOADED_BIT] == $past(s.loaded);
   endproperty
   a_loaded_read: assert property (p_loaded_read) else $error("loaded read wrong");
   property p_valid_read;
      s_rd_stat |=> o_rdata[PAGE_VALID_BIT] == $past(pt.page_valid);
   endproperty
   a_valid_read: assert property (p_valid_read) else $error("page valid read wrong");
   property p_low_read;
      s_rd_stat |=> o_rdata[NOT_LOW_BIT] == $past(pt.not_low);
   endproperty
   a_low_read: assert property (p_low_read) else $error("not low read wrong");
   property p_high_read;
      s_rd_stat |=> o_rdata[NOT_HIGH_BIT] == $past(pt.not_high);
   endproperty
   a_high_read: assert property (p_high_read) else $error("not high read wrong");
   property p_try_read;
      s_rd_stat |=> o_rdata[FIRST_ATTEMPT_BIT] == $past(pt.attempted);
   endproperty
   a_try_read: assert property (p_try_read) else $error("attempt read wrong");

   // Host writes never reach the status flags
   property p_stat_write_ignored;
      i_clk_en && i_wr && i_addr == CUST_PAGE2_STATUS_ADDR && !i_load_done
         |=> $stable(s.loaded) && $stable(s.warn) && $stable(s.err);
   endproperty
   a_stat_write_ignored: assert property (p_stat_write_ignored)
      else $error("write landed");

   // Read data stand for one enabled cycle only; a frozen cycle in
   // between keeps them, so only an enabled idle cycle clears them
   property p_rd_once;
      s_rd_stat ##1 (i_clk_en && !i_rd) |=> o_rdata == '0;
   endproperty
   a_rd_once: assert property (p_rd_once) else $error("read data stood too long");

   // A write never leaves read data behind
   property p_wr_no_data;
      s_wr_only |=> o_rdata == '0;
   endproperty
   a_wr_no_data: assert property (p_wr_no_data) else $error("write left read data");

endmodule : otp_page2_status
`default_nettype wire

//--- logic/otp_prog_tracker.sv
// Tracks one programming attempt on customer page two and keeps the
// supply and validity results. Assumes start and stop are one-cycle
// pulses from the programming engine, stop only after start.
`timescale 1ns/1ps
`default_nettype none
module otp_prog_tracker
   import otp_page2_pkg::*;
(
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_nrst,
   input  wire logic i_clk_en,
   // Link to the status block
   prog_track_if.trk trk
);

   // All tracker state
   typedef struct packed {
      prog_state_t state;       // Attempt in progress or not
      logic        uv_seen;     // Low or high supply seen in this attempt
      logic        ov_seen;     // High supply seen in this attempt
      logic        page_valid;  // Result flags
      logic        not_low;
      logic        not_high;
      logic        attempted;
   } trk_state_t;

   trk_state_t s;       // Registered state
   trk_state_t next_s;  // Next state

   // Next state
   always_comb begin
      next_s = s;
      case (s.state)
         PS_IDLE: begin
            if (trk.start) begin
               // Validity and supply results read zero while the attempt runs
               next_s.attempted  = 1'b1;
               next_s.uv_seen    = 1'b0;
               next_s.ov_seen    = 1'b0;
               next_s.page_valid = 1'b0;
               next_s.not_low    = 1'b0;
               next_s.not_high   = 1'b0;
               next_s.state      = PS_BURN;
            end else if (trk.restore) begin
               // Raw copy: an inconsistent record shows as a format error
               next_s.page_valid = trk.restore_flags[RS_VALID];
               next_s.not_low    = trk.restore_flags[RS_NOT_LOW];
               next_s.not_high   = trk.restore_flags[RS_NOT_HIGH];
               next_s.attempted  = trk.restore_flags[RS_TRY];
            end
         end
         PS_BURN: begin
            // High supply also shuts down as low supply
            next_s.uv_seen = s.uv_seen | trk.uv | trk.ov;
            next_s.ov_seen = s.ov_seen | trk.ov;
            if (trk.stop) begin
               next_s.not_low    = ~next_s.uv_seen;
               next_s.not_high   = ~next_s.ov_seen;
               next_s.page_valid = trk.verify_ok & ~next_s.uv_seen;
               next_s.state      = PS_IDLE;
            end
         end
         default: begin
            next_s.state = PS_IDLE;
         end
      endcase
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s <= '{state: PS_IDLE, default: 1'b0};
      end else if (i_clk_en) begin
         s <= next_s;
      end
   end

   assign trk.page_valid = s.page_valid;
   assign trk.not_low    = s.not_low;
   assign trk.not_high   = s.not_high;
   assign trk.attempted  = s.attempted;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_burn_end;
      i_clk_en && s.state == PS_BURN && trk.stop;
   endsequence
   sequence s_clean;
      !(trk.uv || trk.ov || s.uv_seen || s.ov_seen);
   endsequence

   property p_low_flag;
      s_burn_end ##0 (trk.uv || s.uv_seen) |=> !trk.not_low;
   endproperty
   a_low_flag: assert property (p_low_flag) else $error("low supply not reported");
   property p_high_flag;
      s_burn_end ##0 (trk.ov || s.ov_seen) |=> !trk.not_high;
   endproperty
   a_high_flag: assert property (p_high_flag) else $error("high supply not reported");
   property p_high_drops_low;
      s_burn_end ##0 trk.ov |=> !trk.not_low && !trk.not_high && !trk.page_valid;
   endproperty
   a_high_drops_low: assert property (p_high_drops_low) else $error("low ok kept on high");
   property p_clean_end;
      s_burn_end ##0 s_clean |=> trk.not_low && trk.not_high;
   endproperty
   a_clean_end: assert property (p_clean_end) else $error("clean attempt flagged");
   property p_try_set;
      i_clk_en && s.state == PS_IDLE && trk.start |=> trk.attempted && s.state == PS_BURN;
   endproperty
   a_try_set: assert property (p_try_set) else $error("attempt flag not set");
   property p_try_cause;
      $rose(trk.attempted) |-> $past(trk.start) || $past(trk.restore);
   endproperty
   a_try_cause: assert property (p_try_cause) else $error("attempt flag set without cause");
   property p_valid_cause;
      $rose(trk.page_valid) |-> ($past(trk.stop) && $past(trk.verify_ok)) || $past(trk.restore);
   endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("page valid without cause");

endmodule : otp_prog_tracker
`default_nettype wire

//--- logic/prog_track_if.sv
// Carrier between the status block and its programming attempt tracker.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface prog_track_if;
   import otp_page2_pkg::*;
   logic            start;          // Programming attempt begins
   logic            stop;           // Programming attempt ends
   logic            uv;             // Supply low seen this cycle
   logic            ov;             // Supply high seen this cycle
   logic            verify_ok;      // Page read back good at stop
   logic            restore;        // Load flags from the record
   logic [RS_W-1:0] restore_flags;  // Flags from the record
   logic            page_valid;     // Page usable for loading
   logic            not_low;        // No low or high supply in last attempt
   logic            not_high;       // No high supply in last attempt
   logic            attempted;      // First attempt made

   // Status block side
   modport ctl (output start, stop, uv, ov, verify_ok, restore, restore_flags,
                input  page_valid, not_low, not_high, attempted);
   // Tracker side
   modport trk (input  start, stop, uv, ov, verify_ok, restore, restore_flags,
                output page_valid, not_low, not_high, attempted);
endinterface : prog_track_if
`default_nettype wire

//--- verif/otp_page2_status_tb.sv
// Self-checking bench for the customer page two status block.
// Assumes the block alone on one 125 MHz clock, driven straight at its ports.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module otp_page2_status_tb;
   import otp_page2_pkg::*;
   // Design inputs and outputs
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              clk_en = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0, rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              ld_done = 1'b0, ld_sel = 1'b0, ld_warn = 1'b0, ld_ded = 1'b0;
   logic              p_start = 1'b0, p_stop = 1'b0, p_uv = 1'b0, p_ov = 1'b0;
   logic              p_vok = 1'b0;
   logic              rs = 1'b0;
   logic [RS_W-1:0]   rs_flags = '0;
   logic              irq;
   // Bench state and expectation model
   integer            num_errors = 0;
   integer            cmp_count = 0;
   integer            seed = 27;
   logic [31:0]       r;
   logic [2:0]        ld_m = 3'b000;  // Expected bits 7..5
   logic [3:0]        pg_m = 4'h0;    // Expected bits 3..0
   logic [3:0]        mask_m = 4'h0;
   logic              su, so;

   // Free-running core clock, 8 ns period
   always #4 clk = ~clk;

   otp_page2_status dut (
      .i_sys_clk(clk), .i_nrst(nrst), .i_clk_en(clk_en),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_load_done(ld_done), .i_load_page2_sel(ld_sel), .i_load_sec_warn(ld_warn),
      .i_load_ded_err(ld_ded), .i_prog_start(p_start), .i_prog_stop(p_stop),
      .i_prog_uv(p_uv), .i_prog_ov(p_ov), .i_prog_verify_ok(p_vok),
      .i_restore(rs), .i_restore_flags(rs_flags), .o_irq(irq));

   // Whole status byte as the flags should read; format error is derived
   function automatic logic [7:0] exp_stat(input logic [2:0] l, input logic [3:0] p);
      exp_stat = {l, (p[2] | p[1]) & ~p[0], p};
   endfunction : exp_stat

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // Reset held four cycles, released on a rising edge
   task automatic do_reset;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      ld_m = 3'b000;
      pg_m = 4'h0;
      mask_m = 4'h0;
   endtask : do_reset

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (a == IRQ_MASK_ADDR) mask_m = d[3:0];
   endtask : wr_reg

   // Read data is looked at only in the cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask : rd_chk

   // Interrupt status readback plus the level output under the current mask
   task automatic irq_chk(input logic [3:0] e);
      rd_chk(IRQ_STATUS_ADDR, {4'h0, e});
      `CHK(irq, |(e & mask_m))
   endtask : irq_chk

   task automatic pulse_load(input logic s, input logic w, input logic d);
      @(posedge clk);
      ld_done <= 1'b1;
      ld_sel <= s;
      ld_warn <= w;
      ld_ded <= d;
      @(posedge clk);
      ld_done <= 1'b0;
      ld_m = {s, s & w, s & d};
   endtask : pulse_load

   // One programming attempt of n cycles; uf/of allow low/high supply
   task automatic run_prog(input int n, input logic uf, input logic of, input logic vok);
      @(posedge clk);
      p_start <= 1'b1;
      @(posedge clk);
      p_start <= 1'b0;
      rd_chk(CUST_PAGE2_STATUS_ADDR, exp_stat(ld_m, 4'b0001));
      su = 1'b0;
      so = 1'b0;
      for (int k = 0; k < n; k++) begin
         r = $random(seed);
         @(posedge clk);
         p_uv <= uf & (r[0] | (k == 0));
         p_ov <= of & (r[1] | (k == 0));
         su = su | (uf & (r[0] | (k == 0)));
         so = so | (of & (r[1] | (k == 0)));
         p_stop <= (k == n - 1);
         p_vok <= vok;
      end
      @(posedge clk);
      p_stop <= 1'b0;
      p_uv <= 1'b0;
      p_ov <= 1'b0;
      pg_m = {vok & ~(su | so), ~(su | so), ~so, 1'b1};
   endtask : run_prog

   // Hang guard: a run that outlives this counts as a mismatch
   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      close_out();
   end

   // Main sequence
   initial begin
      do_reset();
      rd_chk(CUST_PAGE2_STATUS_ADDR, 8'h00);
      @(posedge clk);
      #1 `CHK(rdata, 8'h00)
      irq_chk(4'h0);
      rd_chk(IRQ_MASK_ADDR, 8'h00);
      wr_reg(CUST_PAGE2_STATUS_ADDR, 8'hff);
      rd_chk(CUST_PAGE2_STATUS_ADDR, 8'h00);
      wr_reg(16'h051c, 8'hff);
      rd_chk(16'h051c, 8'h00);
      $display("test reset and access done");

      // Every load outcome with the mask clear, then random ones, each with a random mask
      for (int i = 0; i < 16; i++) begin
         r = (i < 8) ? i : $random(seed);
         wr_reg(IRQ_STATUS_ADDR, 8'h0f);
         wr_reg(IRQ_MASK_ADDR, {4'h0, r[6:3]});
         pulse_load(r[0], r[1], r[2]);
         rd_chk(CUST_PAGE2_STATUS_ADDR, exp_stat(ld_m, pg_m));
         irq_chk({2'b00, r[0] & (r[1] | r[2]), 1'b1});
      end
      $display("test loads done");

      // Clean pass, failed verify, high only, low only, then random faults
      for (int j = 0; j < 8; j++) begin
         r = $random(seed);
         wr_reg(IRQ_STATUS_ADDR, 8'h0f);
         wr_reg(IRQ_MASK_ADDR, {4'h0, r[11:8]});
         if (j < 4)
            run_prog(1 + j, j == 3, j == 2, j != 1);
         else
            run_prog(1 + r[2:0], r[3], r[4], r[5]);
         rd_chk(CUST_PAGE2_STATUS_ADDR, exp_stat(ld_m, pg_m));
         irq_chk({su | so, 1'b1, 2'b00});
      end
      $display("test programming done");

      // Every stored record; last one has no format error, so a programming attempt follows
      for (int f = 0; f < 16; f++) begin
         @(posedge clk);
         rs <= 1'b1;
         rs_flags <= f[3:0];
         @(posedge clk);
         rs <= 1'b0;
         pg_m = f[3:0];
         rd_chk(CUST_PAGE2_STATUS_ADDR, exp_stat(ld_m, pg_m));
      end
      $display("test restore done");

      // A restore during an attempt is ignored; then a clean stop
      @(posedge clk);
      p_start <= 1'b1;
      @(posedge clk);
      p_start <= 1'b0;
      rs <= 1'b1;
      @(posedge clk);
      rs <= 1'b0;
      rd_chk(CUST_PAGE2_STATUS_ADDR, exp_stat(ld_m, 4'b0001));
      @(posedge clk);
      p_stop <= 1'b1;
      p_vok <= 1'b1;
      @(posedge clk);
      p_stop <= 1'b0;
      pg_m = 4'b1111;
      $display("test restore in attempt done");

      // A load while the enable is low is lost
      @(posedge clk);
      clk_en <= 1'b0;
      ld_done <= 1'b1;
      ld_sel <= ~ld_m[2];
      @(posedge clk);
      ld_done <= 1'b0;
      clk_en <= 1'b1;
      rd_chk(CUST_PAGE2_STATUS_ADDR, exp_stat(ld_m, pg_m));
      $display("test enable done");

      // Second reset in mid-run clears every flag
      do_reset();
      rd_chk(CUST_PAGE2_STATUS_ADDR, 8'h00);
      irq_chk(4'h0);
      $display("test second reset done");
      close_out();
   end
endmodule : otp_page2_status_tb
`default_nettype wire
